// [hw/ump_consts.svh]
// constants for the mac-facing phy interface block
`ifndef UMP_CONSTS_SVH
`define UMP_CONSTS_SVH

// system clock and derived link clock
`define UMP_PCLK_MHZ          40
`define UMP_LINK_NOMINAL_MHZ  66
`define UMP_LINK_PERIOD_NS    200
`define UMP_LINK_HALF_CYC     ((`UMP_LINK_PERIOD_NS * `UMP_PCLK_MHZ / 1000) / 2)

// internal reset work after release
`define UMP_RESET_WORK_NS     500
`define UMP_RESET_WORK_CYC    ((`UMP_RESET_WORK_NS * `UMP_PCLK_MHZ + 999) / 1000)

// default air-activity delays, rounded up to whole cycles
`define UMP_SYNC_DLY_NS       100
`define UMP_SYNC_DLY_CYC      ((`UMP_SYNC_DLY_NS * `UMP_PCLK_MHZ + 999) / 1000)
`define UMP_END_DLY_NS        50
`define UMP_END_DLY_CYC       ((`UMP_END_DLY_NS * `UMP_PCLK_MHZ + 999) / 1000)

// apb byte offsets
`define UMP_APB_SYNC_DLY      12'h000
`define UMP_APB_END_DLY       12'h004
`define UMP_APB_STATUS        12'h008

// serial management register addresses
`define UMP_SER_PWR_MODE      8'h00
`define UMP_SER_CCA_REQ       8'h01
`define UMP_SER_STATE         8'h02

// power mode field codes
`define UMP_PM_SLEEP          2'h0
`define UMP_PM_STANDBY        2'h1
`define UMP_PM_READY          2'h2

`endif

// [hw/ump_phy_iface.sv]
// phy side of the mac-phy signal interface with an apb register slave
`timescale 1ns/1ps
`include "ump_consts.svh"
module ump_phy_iface (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// control pins from and to the mac
	input  wire logic        interface_reset_n,
	input  wire logic        tx_en,
	input  wire logic        rx_en,
	input  wire logic        clock_stop_request,
	output logic             iface_clk,
	output logic             air_activity,
	// data pins
	output logic             data_strobe,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	// assessment and serial management pins
	output logic             channel_clear_result,
	input  wire logic        serial_in,
	output logic             serial_out,
	output logic             serial_oe,
	// radio core, same clock
	input  wire logic        radio_tx_start,
	input  wire logic        radio_tx_done,
	input  wire logic        radio_tx_req,
	input  wire logic        radio_sync_found,
	input  wire logic        radio_rx_done,
	input  wire logic        radio_rx_valid,
	input  wire logic [7:0]  radio_rx_octet,
	input  wire logic        radio_cca_done,
	input  wire logic        radio_cca_clear,
	output logic      [7:0]  radio_tx_octet,
	output logic             radio_tx_valid,
	output logic             radio_cca_start,
	output logic             tx_path_en,
	output logic             rx_path_en
);
	import ump_pkg::*;

	localparam logic [3:0]  LINK_HALF  = 4'(`UMP_LINK_HALF_CYC);
	localparam logic [7:0]  RESET_WORK = 8'(`UMP_RESET_WORK_CYC);

	logic             arst_n;
	logic [1:0]       rst_pipe;
	logic             core_rst_n;
	logic [3:0]       ctl_s;
	logic             tx_s, rx_s, stop_s, ser_s;
	logic [7:0]       data_s;
	ump_state_t       state, next_state;
	logic [7:0]       reset_cnt;
	logic [1:0]       pwr_mode;
	logic [3:0]       div_cnt;
	logic             clk_run, link_rise;
	logic [15:0]      sync_dly, end_dly, dly_cnt;
	logic             dly_busy, dly_set, act_set_pend, act_clr_pend;
	logic             tx_req_pend, rx_pend, was_tx;
	logic [7:0]       rx_hold;
	ump_ser_t         ser_state;
	logic [2:0]       ser_cnt;
	logic             ser_rw, ser_wr, cca_busy, cca_clear_hold;
	logic [7:0]       ser_addr, ser_shift, ser_wdata, ser_rd;
	logic             apb_acc;

	// interface pin and apb reset both clear the block at once
	assign arst_n = presetn & interface_reset_n;

	// release is synchronised so the state machine never sees a ragged edge
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign core_rst_n = rst_pipe[1];

	// pins from the mac other than interface_reset_n pass two flops before use
	ump_sync2 #(.WIDTH(4)) u_sync_ctl (
		.clk   (pclk),
		.rst_n (arst_n),
		.d     ({tx_en, rx_en, clock_stop_request, serial_in}),
		.q     (ctl_s)
	);
	ump_sync2 #(.WIDTH(8)) u_sync_data (
		.clk   (pclk),
		.rst_n (arst_n),
		.d     (data_in),
		.q     (data_s)
	);
	assign {tx_s, rx_s, stop_s, ser_s} = ctl_s;

	// link clock runs only where the state allows it
	always_comb begin
		case (state)
			st_standby:  clk_run = !stop_s;
			st_ready:    clk_run = 1'b1;
			st_transmit: clk_run = 1'b1;
			st_receive:  clk_run = 1'b1;
			default:     clk_run = 1'b0;
		endcase
	end
	assign link_rise = clk_run && (div_cnt == LINK_HALF - 4'h1) && !iface_clk;

	// divider: the slow link clock is itself a register, launched on pclk
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt   <= 4'h0;
			iface_clk <= 1'b0;
		end else if (!clk_run) begin
			div_cnt   <= 4'h0;
			iface_clk <= 1'b0;
		end else if (div_cnt == LINK_HALF - 4'h1) begin
			div_cnt   <= 4'h0;
			iface_clk <= ~iface_clk;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// readiness state transitions
	always_comb begin
		next_state = state;
		case (state)
			st_reset: begin
				if (core_rst_n && reset_cnt == RESET_WORK - 8'h01)
					next_state = st_standby;
			end
			st_sleep: begin
				// no link clock here, so the requests are watched on pclk
				if (tx_s && rx_s)
					next_state = st_standby;
			end
			st_standby: begin
				if (pwr_mode == `UMP_PM_READY)
					next_state = st_ready;
				else if (pwr_mode == `UMP_PM_SLEEP)
					next_state = st_sleep;
			end
			st_ready: begin
				if (link_rise && tx_s)
					next_state = st_transmit;
				else if (link_rise && rx_s)
					next_state = st_receive;
				else if (pwr_mode == `UMP_PM_SLEEP || pwr_mode == `UMP_PM_STANDBY)
					next_state = st_standby;
			end
			st_transmit: begin
				if (link_rise && !tx_s && !air_activity)
					next_state = st_ready;
			end
			st_receive: begin
				if (link_rise && !rx_s && !air_activity)
					next_state = st_ready;
			end
			default: next_state = st_reset;
		endcase
	end

	// state register and reset work counter
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= st_reset;
			reset_cnt <= 8'h00;
		end else begin
			state     <= next_state;
			reset_cnt <= (state == st_reset && core_rst_n) ? reset_cnt + 8'h01 : 8'h00;
		end
	end

	// radio paths follow the active states
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_path_en <= 1'b0;
			rx_path_en <= 1'b0;
		end else begin
			tx_path_en <= (next_state == st_transmit);
			rx_path_en <= (next_state == st_receive);
		end
	end

	// power mode field: serial writes, forced to standby by reset exit and wake
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_mode <= `UMP_PM_STANDBY;
		end else if (state == st_reset) begin
			pwr_mode <= `UMP_PM_STANDBY;
		end else if (state == st_sleep && next_state == st_standby) begin
			pwr_mode <= `UMP_PM_STANDBY;
		end else if (ser_wr && ser_addr == `UMP_SER_PWR_MODE) begin
			pwr_mode <= ser_wdata[1:0];
		end
	end

	// air activity: transmit edges pass straight, receive edges run a delay
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			air_activity <= 1'b0;
			act_set_pend <= 1'b0;
			act_clr_pend <= 1'b0;
			dly_cnt      <= 16'h0000;
			dly_busy     <= 1'b0;
			dly_set      <= 1'b0;
		end else begin
			if (link_rise) begin
				if (act_set_pend)
					air_activity <= 1'b1;
				else if (act_clr_pend)
					air_activity <= 1'b0;
				act_set_pend <= 1'b0;
				act_clr_pend <= 1'b0;
			end
			if (dly_busy) begin
				if (dly_cnt == 16'h0000) begin
					dly_busy <= 1'b0;
					if (dly_set)
						act_set_pend <= 1'b1;
					else
						act_clr_pend <= 1'b1;
				end else begin
					dly_cnt <= dly_cnt - 16'h0001;
				end
			end
			// new events come last so they win over the consumption above
			if (state == st_transmit && radio_tx_start)
				act_set_pend <= 1'b1;
			if (state == st_transmit && radio_tx_done)
				act_clr_pend <= 1'b1;
			if (state == st_receive && radio_sync_found) begin
				dly_cnt  <= sync_dly;
				dly_busy <= 1'b1;
				dly_set  <= 1'b1;
			end else if (state == st_receive && radio_rx_done) begin
				dly_cnt  <= end_dly;
				dly_busy <= 1'b1;
				dly_set  <= 1'b0;
			end
		end
	end

	// data strobe and octet flow in both directions
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			data_strobe    <= 1'b0;
			data_out       <= 8'h00;
			tx_req_pend    <= 1'b0;
			rx_pend        <= 1'b0;
			rx_hold        <= 8'h00;
			radio_tx_octet <= 8'h00;
			radio_tx_valid <= 1'b0;
		end else begin
			radio_tx_valid <= 1'b0;
			if (link_rise) begin
				if (state == st_transmit && data_strobe) begin
					radio_tx_octet <= data_s;
					radio_tx_valid <= 1'b1;
				end
				if (state == st_transmit) begin
					data_strobe <= tx_req_pend;
					tx_req_pend <= 1'b0;
				end else if (state == st_receive) begin
					data_strobe <= rx_pend;
					if (rx_pend)
						data_out <= rx_hold;
					rx_pend <= 1'b0;
				end else begin
					data_strobe <= 1'b0;
				end
			end
			if (state == st_transmit && radio_tx_req)
				tx_req_pend <= 1'b1;
			if (state == st_receive && radio_rx_valid) begin
				rx_pend <= 1'b1;
				rx_hold <= radio_rx_octet;
			end
		end
	end

	// bus release on entry reacts to the request itself, and re-drive after
	// transmit waits one whole link cycle so both ends never overlap
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			data_oe <= 1'b1;
			was_tx  <= 1'b0;
		end else begin
			if (state == st_transmit)
				was_tx <= 1'b1;
			else if (link_rise)
				was_tx <= 1'b0;
			data_oe <= !(tx_s && state == st_ready) && state != st_transmit
				&& !was_tx;
		end
	end

	// serial read data
	always_comb begin
		case (ser_addr)
			`UMP_SER_PWR_MODE: ser_rd = {6'h00, pwr_mode};
			`UMP_SER_CCA_REQ:  ser_rd = {7'h00, cca_busy};
			`UMP_SER_STATE:    ser_rd = {5'h00, 3'(state)};
			default:           ser_rd = 8'h00;
		endcase
	end

	// serial management slave: start, read flag, 8 address bits, 8 data bits
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			ser_state  <= ser_idle;
			ser_cnt    <= 3'h0;
			ser_rw     <= 1'b0;
			ser_addr   <= 8'h00;
			ser_shift  <= 8'h00;
			ser_wdata  <= 8'h00;
			ser_wr     <= 1'b0;
			serial_out <= 1'b0;
			serial_oe  <= 1'b0;
		end else begin
			ser_wr <= 1'b0;
			if (state == st_reset) begin
				ser_state <= ser_idle;
				serial_oe <= 1'b0;
			end else if (link_rise) begin
				case (ser_state)
					ser_idle: begin
						if (ser_s)
							ser_state <= ser_dir;
					end
					ser_dir: begin
						ser_rw    <= ser_s;
						ser_cnt   <= 3'h7;
						ser_state <= ser_abits;
					end
					ser_abits: begin
						ser_addr <= {ser_addr[6:0], ser_s};
						ser_cnt  <= ser_cnt - 3'h1;
						if (ser_cnt == 3'h0)
							ser_state <= ser_rw ? ser_rdata : ser_dbits;
					end
					ser_dbits: begin
						ser_shift <= {ser_shift[6:0], ser_s};
						ser_cnt   <= ser_cnt - 3'h1;
						if (ser_cnt == 3'h0) begin
							ser_wdata <= {ser_shift[6:0], ser_s};
							ser_wr    <= 1'b1;
							ser_state <= ser_idle;
						end
					end
					ser_rdata: begin
						// phy owns the line only for the read data bits
						if (!serial_oe) begin
							serial_oe  <= 1'b1;
							serial_out <= ser_rd[7];
							ser_shift  <= {ser_rd[6:0], 1'b0};
						end else if (ser_cnt == 3'h0) begin
							serial_oe <= 1'b0;
							ser_state <= ser_idle;
						end else begin
							serial_out <= ser_shift[7];
							ser_shift  <= {ser_shift[6:0], 1'b0};
							ser_cnt    <= ser_cnt - 3'h1;
						end
					end
					default: ser_state <= ser_idle;
				endcase
			end
		end
	end

	// clear channel assessment: start pulse, result launched on a link edge
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			radio_cca_start      <= 1'b0;
			cca_busy             <= 1'b0;
			cca_clear_hold       <= 1'b0;
			channel_clear_result <= 1'b0;
		end else begin
			radio_cca_start <= 1'b0;
			if (link_rise && !cca_busy)
				channel_clear_result <= cca_clear_hold;
			if (radio_cca_done) begin
				cca_busy       <= 1'b0;
				cca_clear_hold <= radio_cca_clear;
			end
			if (ser_wr && ser_addr == `UMP_SER_CCA_REQ && ser_wdata[0]) begin
				radio_cca_start <= 1'b1;
				cca_busy        <= 1'b1;
				cca_clear_hold  <= 1'b0;
			end
		end
	end

	// apb: one wait state, so pready and prdata both come from flops
	assign apb_acc = psel && penable && pready;
	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			sync_dly <= 16'(`UMP_SYNC_DLY_CYC);
			end_dly  <= 16'(`UMP_END_DLY_CYC);
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready) begin
				case (paddr)
					`UMP_APB_SYNC_DLY: prdata <= {16'h0000, sync_dly};
					`UMP_APB_END_DLY:  prdata <= {16'h0000, end_dly};
					`UMP_APB_STATUS: begin
						prdata  <= {24'h0000_00, air_activity, pwr_mode, 2'b00, 3'(state)};
						pslverr <= pwrite;
					end
					default: pslverr <= 1'b1;
				endcase
			end
			if (apb_acc && pwrite && paddr == `UMP_APB_SYNC_DLY)
				sync_dly <= pwdata[15:0];
			if (apb_acc && pwrite && paddr == `UMP_APB_END_DLY)
				end_dly <= pwdata[15:0];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!arst_n);

	property p_reset_exit;
		$past(state) == st_reset && state == st_standby |-> pwr_mode == `UMP_PM_STANDBY;
	endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("standby without mode");

	property p_held_reset;
		!core_rst_n |=> state == st_reset;
	endproperty
	a_held_reset: assert property (p_held_reset) else $error("left reset early");

	property p_tx_enter;
		state == st_ready && link_rise && tx_s |=> state == st_transmit ##1 tx_path_en;
	endproperty
	a_tx_enter: assert property (p_tx_enter) else $error("transmit not entered");

	property p_rx_enter;
		state == st_ready && link_rise && rx_s && !tx_s |=> state == st_receive;
	endproperty
	a_rx_enter: assert property (p_rx_enter) else $error("receive not entered");

	property p_wake;
		state == st_sleep && tx_s && rx_s |=> state == st_standby;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from sleep");

	property p_tx_active;
		state == st_transmit && act_set_pend && link_rise |=> air_activity;
	endproperty
	a_tx_active: assert property (p_tx_active) else $error("activity missed");

	property p_rx_delay;
		state == st_receive && radio_sync_found && sync_dly == 16'h0006 && !radio_rx_done
			|=> !act_set_pend [*7] ##1 act_set_pend;
	endproperty
	a_rx_delay: assert property (p_rx_delay) else $error("sync delay wrong");

	property p_stop;
		(state == st_standby && stop_s) [*2] |-> !iface_clk;
	endproperty
	a_stop: assert property (p_stop) else $error("clock not stopped");

	property p_link_edge;
		link_rise |=> iface_clk ##[4:4] !iface_clk;
	endproperty
	a_link_edge: assert property (p_link_edge) else $error("link period wrong");

	property p_rx_strobe;
		data_strobe && state == st_receive |-> data_oe;
	endproperty
	a_rx_strobe: assert property (p_rx_strobe) else $error("strobe without drive");

	property p_bus_owner;
		state == st_transmit |=> !data_oe;
	endproperty
	a_bus_owner: assert property (p_bus_owner) else $error("bus driven in transmit");

	property p_cca;
		ser_wr && ser_addr == `UMP_SER_CCA_REQ && ser_wdata[0] |=> radio_cca_start && cca_busy;
	endproperty
	a_cca: assert property (p_cca) else $error("assessment not started");

	property p_ser_drive;
		serial_oe |-> ser_state == ser_rdata;
	endproperty
	a_ser_drive: assert property (p_ser_drive) else $error("serial driven outside read");

	property p_sleep_clk;
		state == st_sleep |=> !iface_clk;
	endproperty
	a_sleep_clk: assert property (p_sleep_clk) else $error("clock runs in sleep");

	c_tx:    cover property (state == st_transmit && radio_tx_valid);
	c_rx:    cover property (state == st_receive && data_strobe);
	c_cca:   cover property (radio_cca_done ##[1:50] channel_clear_result);
	c_wake:  cover property (state == st_sleep ##1 state == st_standby);
endmodule

// [hw/ump_pkg.sv]
// types shared by the mac-facing phy interface block
package ump_pkg;
	typedef enum logic [2:0] {
		st_reset, st_sleep, st_standby, st_ready, st_transmit, st_receive
	} ump_state_t;
	typedef enum logic [2:0] {
		ser_idle, ser_dir, ser_abits, ser_dbits, ser_rdata
	} ump_ser_t;
endpackage

// [hw/ump_sync2.sv]
// two-flop level synchroniser for pins from outside the pclk domain
`timescale 1ns/1ps
module ump_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// level in and synchronised level out
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// [verif/test_uwb_mac_phy_signal_interface.sv]
// self-checking bench for the phy side of the mac-phy signal interface
`timescale 1ns/1ps
module test_uwb_mac_phy_signal_interface;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        interface_reset_n, tx_en, rx_en, clock_stop_request, iface_clk;
	logic        air_activity, data_strobe, data_oe, channel_clear_result;
	logic        serial_in, serial_out, serial_oe, radio_tx_start, radio_tx_done;
	logic        radio_tx_req, radio_sync_found, radio_rx_done, radio_rx_valid;
	logic        radio_cca_done, radio_cca_clear, radio_tx_valid, radio_cca_start;
	logic        tx_path_en, rx_path_en;
	logic [7:0]  data_in, data_out, radio_rx_octet, radio_tx_octet, q;
	int          failures, cmp_count, n;
	// link cycles the mac waits after activity falls; a plain default
	localparam int tx_to_rx_dwell_time = 4;

	ump_phy_iface DUT (.*);
	ump_mac_model mac (.*);

	// free-running system clock
	always #12.5 pclk = ~pclk;

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// bounded wait; the caller compares afterwards
	task automatic wt(ref logic s, input logic v);
		for (n = 0; n < 400 && s !== v; n++)
			@(posedge pclk);
	endtask
	task automatic t_regs;
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("status", rd, 32'h0000_0022);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("end_dly", rd, 32'h0000_0002);
		apb(1'b1, 12'h000, 32'hffff_0006);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk("sync_dly", rd, 32'h0000_0006);
		apb(1'b1, 12'h008, 32'h0000_0000);
		chk("ro_status", err, 1'b1);
		apb(1'b0, 12'h00c, 32'h0000_0000);
		chk("unmapped_err", err, 1'b1);
		chk("unmapped_data", rd, 32'h0000_0000);
	endtask
	task automatic t_ready;
		mac.ser(1'b0, 8'h00, 8'h02, q);
		repeat (16) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("ready", rd, 32'h0000_0043);
		mac.ser(1'b1, 8'h00, 8'h00, q);
		chk("pm_read", q, 8'h02);
	endtask
	task automatic t_tx;
		mac.req(1'b1, 1'b0);
		wt(tx_path_en, 1'b1);
		chk("tx_path", {tx_path_en, data_oe}, 2'b10);
		radio_tx_start <= 1'b1;
		@(posedge pclk);
		radio_tx_start <= 1'b0;
		wt(air_activity, 1'b1);
		chk("tx_air", air_activity, 1'b1);
		radio_tx_req <= 1'b1;
		@(posedge pclk);
		radio_tx_req <= 1'b0;
		wt(radio_tx_valid, 1'b1);
		chk("tx_octet", radio_tx_octet, 8'h5a);
		radio_tx_done <= 1'b1;
		@(posedge pclk);
		radio_tx_done <= 1'b0;
		wt(air_activity, 1'b0);
		chk("tx_air_end", air_activity, 1'b0);
		mac.req(1'b0, 1'b0);
		wt(data_oe, 1'b1);
		chk("tx_release", data_oe, 1'b1);
	endtask
	task automatic t_rx;
		repeat (tx_to_rx_dwell_time) @(posedge iface_clk);
		mac.req(1'b0, 1'b1);
		wt(rx_path_en, 1'b1);
		chk("rx_path", rx_path_en, 1'b1);
		radio_sync_found <= 1'b1;
		@(posedge pclk);
		radio_sync_found <= 1'b0;
		for (n = 1; n < 80 && air_activity !== 1'b1; n++)
			@(posedge pclk);
		chk("rx_air", {air_activity, n >= 8}, 2'b11);
		radio_rx_octet <= 8'hc3;
		radio_rx_valid <= 1'b1;
		@(posedge pclk);
		radio_rx_valid <= 1'b0;
		wt(data_strobe, 1'b1);
		chk("rx_data", {data_oe, data_out}, 9'h1c3);
		radio_rx_done <= 1'b1;
		@(posedge pclk);
		radio_rx_done <= 1'b0;
		wt(air_activity, 1'b0);
		chk("rx_air_end", air_activity, 1'b0);
		mac.req(1'b0, 1'b0);
	endtask
	task automatic t_cca;
		fork
			mac.ser(1'b0, 8'h01, 8'h01, q);
			begin
				// the start pulse stands one pclk, so look at it where the wait ends
				wt(radio_cca_start, 1'b1);
				chk("cca_start", radio_cca_start, 1'b1);
			end
		join
		radio_cca_clear <= 1'b1;
		radio_cca_done  <= 1'b1;
		@(posedge pclk);
		radio_cca_done  <= 1'b0;
		wt(channel_clear_result, 1'b1);
		chk("cca_result", channel_clear_result, 1'b1);
	endtask
	// reset in mid-receive, then the clock stop in standby
	task automatic t_rst;
		mac.req(1'b0, 1'b1);
		wt(rx_path_en, 1'b1);
		interface_reset_n <= 1'b0;
		#2;
		chk("async_rst", {rx_path_en, data_oe}, 2'b01);
		@(posedge pclk);
		interface_reset_n <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("rst_standby", rd, 32'h0000_0022);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk("rst_sync_dly", rd, 32'h0000_0004);
		mac.req(1'b0, 1'b0);
		clock_stop_request <= 1'b1;
		repeat (16) @(posedge pclk);
		n = 0;
		repeat (32) begin
			@(posedge pclk);
			n += iface_clk;
		end
		chk("clk_stop", n, 0);
		clock_stop_request <= 1'b0;
		wt(iface_clk, 1'b1);
		chk("clk_run", iface_clk, 1'b1);
	endtask
	// power mode zero puts the phy to sleep, both requests high wake it
	task automatic t_sleep;
		mac.ser(1'b0, 8'h00, 8'h00, q);
		repeat (16) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("sleep", {rd[7:0], iface_clk}, 9'h002);
		mac.wake;
		repeat (8) @(posedge pclk);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("wake", rd, 32'h0000_0022);
		mac.req(1'b0, 1'b0);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// stimulus: reset, then each scenario in turn
	initial begin
		{pclk, psel, penable, pwrite, presetn, clock_stop_request, radio_tx_start} = '0;
		{radio_tx_done, radio_tx_req, radio_sync_found, radio_rx_done} = '0;
		{radio_rx_valid, radio_cca_done, radio_cca_clear} = '0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		radio_rx_octet = 8'h00;
		interface_reset_n = 1'b1;
		failures = 0;
		cmp_count = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (30) @(posedge pclk);
		t_regs;
		t_ready;
		t_tx;
		t_rx;
		t_cca;
		t_rst;
		t_sleep;
		stop_test;
	end
	// watchdog well beyond the roughly one thousand cycles the scenarios need
	initial begin
		repeat (60000) @(posedge pclk);
		failures++;
		stop_test;
	end
endmodule

// [verif/ump_mac_model.sv]
// mac-side partner model for the link pins of the phy block
`timescale 1ns/1ps
module ump_mac_model (
	// link pins seen from the mac
	input  wire logic       iface_clk,
	input  wire logic       data_strobe,
	input  wire logic       data_oe,
	input  wire logic [7:0] data_out,
	input  wire logic       serial_out,
	input  wire logic       serial_oe,
	output logic            tx_en,
	output logic            rx_en,
	output logic      [7:0] data_in,
	output logic            serial_in
);
	logic       s_drv, s_bit, d_drv;
	logic [7:0] d_val, nxt;
	initial begin
		{tx_en, rx_en, s_drv, s_bit, d_drv} = '0;
		d_val = 8'h00;
		nxt   = 8'h5a;
	end
	// pulled-down serial line, so a released line never fakes a start bit
	assign serial_in = serial_oe ? serial_out : (s_drv & s_bit);
	// undriven bus shows the inverse of the last octet, never a stale copy
	assign data_in = d_drv ? d_val : (data_oe ? data_out : ~d_val);
	// octet follows each strobe seen while tx_en is high, half a link period later
	always @(negedge iface_clk) begin
		if (data_strobe && tx_en) begin
			d_val <= nxt;
			nxt   <= nxt + 8'h01;
			d_drv <= 1'b1;
		end
		if (!tx_en)
			d_drv <= 1'b0;
	end
	// requests change just after a link rising edge
	task automatic req(input logic t, input logic r);
		@(posedge iface_clk);
		tx_en <= t;
		rx_en <= r;
	endtask
	// sleep has no link clock, so the wake levels go out on the caller's pclk edge
	task automatic wake;
		tx_en <= 1'b1;
		rx_en <= 1'b1;
	endtask
	// start bit, direction, address msb first, then write or read data
	task automatic ser(input logic rd, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [17:0] f;
		int          i;
		f = {1'b1, rd, a, d};
		q = 8'h00;
		for (i = 17; i >= (rd ? 8 : 0); i--) begin
			@(posedge iface_clk);
			s_drv <= 1'b1;
			s_bit <= f[i];
		end
		@(posedge iface_clk);
		s_drv <= 1'b0;
		if (rd) begin
			@(negedge iface_clk);
			for (i = 0; i < 8 && serial_oe !== 1'b1; i++)
				@(negedge iface_clk);
			for (i = 7; i >= 0; i--) begin
				q[i] = serial_out;
				@(negedge iface_clk);
			end
		end
	endtask
endmodule
